// ==== src/flash_port_pkg.sv ====
// Purpose: constants and types of the flash programming port
// Assumes: 100 MHz clock, AXI4-Lite register access
// Notes: mode codes are {en_a, en_b, sel_a, sel_b, sel_c}
`default_nettype none
package flash_port_pkg;
  // clock rate and self-timed intervals
  localparam int CLK_MHZ = 100;
  localparam int WRITE_TIME_US = 50;
  localparam int WRITE_MAX_US = 80;
  localparam int ERASE_TIME_MS = 150;
  localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_MS * 1000 * CLK_MHZ;
  // register map
  localparam int AXI_AW = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] LAST_OFS = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_LSB = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // mode line patterns
  localparam logic [4:0] MODE_WRITE_CODE = 5'h0F;
  localparam logic [4:0] MODE_READ_CODE = 5'h03;
  localparam logic [4:0] MODE_WRITE_LOCK_ONE = 5'h1F;
  localparam logic [4:0] MODE_WRITE_LOCK_TWO = 5'h1C;
  localparam logic [4:0] MODE_WRITE_LOCK_THREE = 5'h16;
  localparam logic [4:0] MODE_READ_LOCK = 5'h1A;
  localparam logic [4:0] MODE_ERASE = 5'h14;
  localparam logic [4:0] MODE_READ_SIG = 5'h00;
  // data layout
  localparam logic [7:0] ERASED = 8'hFF;
  localparam int POLL_BIT = 7;
  localparam int LOCK_DATA_LSB = 2;
  localparam logic [13:0] SIG_MAKER_ADR = 14'h0000;
  localparam logic [13:0] SIG_DEV1_ADR = 14'h0100;
  localparam logic [13:0] SIG_DEV2_ADR = 14'h0200;
  typedef enum logic {S_IDLE, S_BUSY} state_t;
  typedef enum logic [1:0] {OP_CODE, OP_LOCK, OP_ERASE} op_t;
  typedef struct packed {
    logic rst;
    logic code_fetch_strobe_n;
    logic program_strobe_n;
    logic program_voltage_enable;
    logic [4:0] mode;
    logic top_address_bit;
    logic [13:0] addr;
    logic [7:0] data;
  } prog_pins_t;
  localparam prog_pins_t PINS_RESET = '{rst: 1'b0,
    code_fetch_strobe_n: 1'b1, program_strobe_n: 1'b1,
    program_voltage_enable: 1'b0, mode: 5'h00, top_address_bit: 1'b0,
    addr: 14'h0000, data: 8'h00};
  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } axi_in_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_out_t;
endpackage
`default_nettype wire

// ==== src/flash_program_port.sv ====
// Purpose: parallel programming and verify port of the code flash
// Assumes: pins are asynchronous and pass two flip-flops first
// Notes: storage is flip-flops; erased state reads as all ones
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module flash_program_port
  import flash_port_pkg::*;
#(
  parameter int MEM_DEPTH = 20480,
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV1_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV2_CODE = 8'h71 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // programming pins
  input wire prog_pins_t pins_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic write_progress_out,
  // register bus
  input wire axi_in_t axi_in,
  output axi_out_t axi_out
);
  localparam int CW = $clog2(ERASE_CYCLES + 1);

  logic rst_ff1, rst_n;
  prog_pins_t pins_s1, pins;
  logic strobe_d;
  state_t state;
  op_t op;
  logic [CW-1:0] cnt;
  logic [2:0] locks;
  logic [14:0] last_addr;
  logic [7:0] last_data;
  logic [7:0] mem [MEM_DEPTH];
  logic ctrl_en;
  logic aw_held, w_held, wr_strobe;
  logic wstrb0_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_ff1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_n <= rst_ff1;
    end
  end

  // strobe_d trails the second stage only, for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1 <= PINS_RESET;
      pins <= PINS_RESET;
      strobe_d <= 1'b1;
    end else begin
      pins_s1 <= pins_in;
      pins <= pins_s1;
      strobe_d <= pins.program_strobe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode and start conditions
  wire [14:0] addr = {pins.top_address_bit, pins.addr};
  wire prog_active = pins.rst & ~pins.code_fetch_strobe_n & ctrl_en;
  wire strobe_rise = pins.program_strobe_n & ~strobe_d;
  wire is_wcode = pins.mode == MODE_WRITE_CODE;
  wire is_rcode = pins.mode == MODE_READ_CODE;
  wire is_wlb1 = pins.mode == MODE_WRITE_LOCK_ONE;
  wire is_wlb2 = pins.mode == MODE_WRITE_LOCK_TWO;
  wire is_wlb3 = pins.mode == MODE_WRITE_LOCK_THREE;
  wire is_rlock = pins.mode == MODE_READ_LOCK;
  wire is_erase = pins.mode == MODE_ERASE;
  wire is_rsig = pins.mode == MODE_READ_SIG;
  // strobe only counts with program voltage and an idle engine
  wire start_ok = prog_active & strobe_rise & pins.program_voltage_enable
    & (state == S_IDLE);
  wire start_code = start_ok & is_wcode & ~locks[0];
  wire start_lock = start_ok & (is_wlb1 | is_wlb2 | is_wlb3);
  wire start_erase = start_ok & is_erase;
  wire start_any = start_code | start_lock | start_erase;
  wire done = (state == S_BUSY) && (cnt == '0);
  wire in_range = 32'(last_addr) < MEM_DEPTH;
  wire rd_range = 32'(addr) < MEM_DEPTH;

  ////////////////////////////////////////////////////////////////////////
  // write engine: one byte, one lock bit or a chip erase per strobe, self-timed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= OP_CODE;
      cnt <= '0;
      last_addr <= '0;
      last_data <= ERASED;
    end else if (start_any) begin
      state <= S_BUSY;
      op <= start_erase ? OP_ERASE : (start_lock ? OP_LOCK : OP_CODE);
      cnt <= start_erase ? CW'(ERASE_CYCLES - 1) : CW'(WRITE_CYCLES - 1);
      if (start_code) begin
        last_addr <= addr;
        last_data <= pins.data;
      end
    end else if (done) begin
      state <= S_IDLE;
    end else if (state == S_BUSY) begin
      cnt <= cnt - CW'(1);
    end
  end

  // lock bits; the pattern captured at the strobe picks the bit
  logic [2:0] lock_sel;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_sel <= 3'b000;
      locks <= 3'b000;
    end else begin
      if (start_lock) begin
        lock_sel <= {is_wlb3, is_wlb2, is_wlb1};
      end
      if (done && op == OP_LOCK) begin
        locks <= locks | lock_sel;
      end else if (done && op == OP_ERASE) begin
        locks <= 3'b000;
      end
    end
  end

  // array commits at completion; till then polling reads last_data with bit 7 inverted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= ERASED;
      end
    end else if (done && op == OP_ERASE) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= ERASED;
      end
    end else if (done && op == OP_CODE && in_range) begin
      mem[last_addr] <= last_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  function automatic logic [7:0] sig_byte(input logic [13:0] a);
    if (a == SIG_MAKER_ADR) begin
      return MAKER_CODE;
    end else if (a == SIG_DEV1_ADR) begin
      return DEV1_CODE;
    end else if (a == SIG_DEV2_ADR) begin
      return DEV2_CODE;
    end
    return ERASED;
  endfunction

  wire code_locked = locks[0] | locks[1];
  wire polling = (state == S_BUSY) && (op == OP_CODE) && (addr == last_addr);
  wire [7:0] stored = rd_range ? mem[addr] : ERASED;
  wire [7:0] poll_byte = {~last_data[POLL_BIT], last_data[6:0]};
  wire [7:0] lock_byte = 8'({locks, 2'b00});
  wire [7:0] next_data = is_rlock ? lock_byte
    : is_rsig ? sig_byte(pins.addr)
    : polling ? poll_byte : stored;
  wire next_oe = prog_active
    & ((is_rcode & ~code_locked) | is_rlock | is_rsig);

  // data leaves from flops; ready is low while the engine runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      write_progress_out <= 1'b1;
    end else begin
      data_out <= next_data;
      data_oe <= next_oe;
      write_progress_out <= ~(start_any | (state == S_BUSY & ~done));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus slave; address and data may arrive in either order
  wire awready_c = ~aw_held & ~bvalid_q;
  wire wready_c = ~w_held & ~bvalid_q;
  wire arready_c = ~rvalid_q;
  assign wr_strobe = aw_held & w_held;
  // one driver for the whole outbound struct
  assign axi_out = '{awready: awready_c, wready: wready_c,
    bvalid: bvalid_q, bresp: bresp_q, arready: arready_c,
    rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
  wire wr_ctrl = awaddr_q == CTRL_OFS;
  wire [AXI_AW-1:0] ra = axi_in.araddr;
  wire [31:0] status_word = 32'({locks, state == S_BUSY});
  wire rd_hit = (ra == CTRL_OFS) | (ra == STATUS_OFS) | (ra == LAST_OFS);
  wire [31:0] rd_word = (ra == CTRL_OFS) ? 32'(ctrl_en)
    : (ra == STATUS_OFS) ? status_word
    : (ra == LAST_OFS) ? 32'(last_addr) : 32'h0000_0000;

  // write channel capture and response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      ctrl_en <= CTRL_EN_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (axi_in.awvalid && awready_c) begin
        aw_held <= 1'b1;
        awaddr_q <= axi_in.awaddr;
      end
      // strobe kept with the data, the master may drop wvalid early
      if (axi_in.wvalid && wready_c) begin
        w_held <= 1'b1;
        wdata_q <= axi_in.wdata;
        wstrb0_q <= axi_in.wstrb[0];
      end
      if (wr_strobe) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
        // only the low lane carries the enable bit
        if (wr_ctrl && wstrb0_q) begin
          ctrl_en <= wdata_q[CTRL_EN_BIT];
        end
      end else if (bvalid_q && axi_in.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel; answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (axi_in.arvalid && arready_c) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axi_in.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence write_started;
    start_code ##1 (state == S_BUSY && op == OP_CODE);
  endsequence

  busy_after_strobe_a: assert property (
    start_any |=> !write_progress_out && state == S_BUSY)
    else $error("ready not dropped after strobe");
  write_length_a: assert property (
    write_started |-> cnt == CW'(WRITE_CYCLES - 1))
    else $error("write interval wrong");
  write_bound_a: assert property (
    (state == S_BUSY && op != OP_ERASE) |-> cnt < CW'(WRITE_CYCLES))
    else $error("write exceeds its interval");
  ready_return_a: assert property (
    done |=> write_progress_out && state == S_IDLE)
    else $error("ready not restored at end of write");
  poll_invert_a: assert property (
    (polling && is_rcode && !is_rlock && !is_rsig) |=>
      data_out[7] == ~last_data[7])
    else $error("polling bit not inverted");
  lock_block_a: assert property (
    (locks[0] && is_wcode && state == S_IDLE) |=> state == S_IDLE)
    else $error("write accepted with lock bit one set");
  vpp_gate_a: assert property (
    (state == S_IDLE && !pins.program_voltage_enable) |=> state == S_IDLE)
    else $error("strobe accepted without program voltage");
  verify_block_a: assert property (
    (is_rcode && code_locked) |=> !data_oe)
    else $error("code readback while locked");
  lock_read_a: assert property (
    (prog_active && is_rlock) |=> data_oe && data_out[4:2] == $past(locks))
    else $error("lock bits not reported");
  maker_read_a: assert property (
    (prog_active && is_rsig && pins.addr == SIG_MAKER_ADR) |=>
      data_out == MAKER_CODE)
    else $error("maker code not returned");
  true_data_a: assert property (
    (done && op == OP_CODE && in_range) ##1
      (is_rcode && addr == $past(last_addr) && state == S_IDLE) |=>
      data_out == $past(last_data, 2))
    else $error("stored byte not presented after write");
endmodule
`default_nettype wire

// ==== test/flash_programmer.sv ====
// Purpose: model of the external parallel programmer
// Assumes: data port has external pull-ups whenever the port releases it
// Notes: setup and hold are generous; the programmer polls bit 7 mid-write
`default_nettype none
module flash_programmer
  import flash_port_pkg::*;
(
  // clock
  input wire logic clk,
  // lines toward the port
  output prog_pins_t pins,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic write_progress_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bus;
  // released data port floats up through the pull-ups
  assign bus = data_oe ? data_out : 8'hFF;
  initial pins = PINS_RESET;
  ////////////////////////////////////////////////////////////////////////////
  // enter programming mode
  task automatic enter();
    pins.rst <= 1'b1;
    pins.code_fetch_strobe_n <= 1'b0;
  endtask
  // address, then data, then mode, then program voltage
  task automatic step(input logic [4:0] m, input logic [14:0] a,
                      input logic [7:0] d, input logic vpp);
    @(posedge clk);
    pins.addr <= a[13:0];
    pins.top_address_bit <= a[14];
    @(posedge clk);
    pins.data <= d;
    @(posedge clk);
    pins.mode <= m;
    repeat (50) @(posedge clk);
    pins.program_voltage_enable <= vpp;
  endtask
  // one strobe; sample busy, poll, then hold until ready returns
  task automatic pulse(input int width, output logic busy,
                       output logic [7:0] poll);
    repeat (20) @(posedge clk);
    pins.program_strobe_n <= 1'b0;
    repeat (width) @(posedge clk);
    pins.program_strobe_n <= 1'b1;
    repeat (6) @(negedge clk);
    busy = !write_progress_out;
    @(posedge clk);
    pins.mode <= MODE_READ_CODE;
    repeat (5) @(negedge clk);
    poll = bus;
    // no cycle limit here: the bench's hang guard ends a stuck write
    while (!write_progress_out) begin
      @(negedge clk);
    end
    @(posedge clk);
    pins.program_voltage_enable <= 1'b0;
  endtask
  // verify-style read in any read mode
  task automatic read(input logic [4:0] m, input logic [14:0] a,
                      output logic [7:0] d, output logic oe);
    @(posedge clk);
    pins.mode <= m;
    pins.addr <= a[13:0];
    pins.top_address_bit <= a[14];
    repeat (6) @(negedge clk);
    d = bus;
    oe = data_oe;
  endtask
endmodule
`default_nettype wire

// ==== test/parallel_flash_program_port_bench.sv ====
// Purpose: self-checking bench of the flash programming port
// Assumes: short write and erase counts keep the run brief
// Notes: AXI master samples ready at the falling edge, acts on the rising
`default_nettype none
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module parallel_flash_program_port_bench
  import flash_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MK = 8'h4B; // arbitrary value
  localparam logic [7:0] D1 = 8'hC2; // arbitrary value
  localparam logic [7:0] D2 = 8'h39; // arbitrary value
  logic clk = 1'b0;
  logic arst_n;
  prog_pins_t pins;
  logic [7:0] data_out, d;
  logic data_oe, write_progress_out, oe, busy;
  logic [7:0] poll;
  logic [31:0] v;
  logic [1:0] r;
  axi_in_t axi_in;
  axi_out_t axo;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;
  logic [13:0] sig_a [3] = '{SIG_MAKER_ADR, SIG_DEV1_ADR, SIG_DEV2_ADR};
  logic [7:0] sig_v [3] = '{MK, D1, D2};
  logic [4:0] lk_m [3] = '{MODE_WRITE_LOCK_THREE, MODE_WRITE_LOCK_ONE,
    MODE_WRITE_LOCK_TWO};
  logic [2:0] lk_e [3] = '{3'b100, 3'b101, 3'b111};
  always #5 clk = ~clk;
  flash_program_port #(.WRITE_CYCLES(20), .ERASE_CYCLES(40),
    .MAKER_CODE(MK), .DEV1_CODE(D1), .DEV2_CODE(D2)) u_dut (
    .clk(clk), .arst_n(arst_n), .pins_in(pins), .data_out(data_out),
    .data_oe(data_oe), .write_progress_out(write_progress_out),
    .axi_in(axi_in), .axi_out(axo));
  flash_programmer u_prog (.clk(clk), .pins(pins), .data_out(data_out),
    .data_oe(data_oe), .write_progress_out(write_progress_out));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // AXI write: both channels offered together, bready held until bvalid
  task automatic axw(input logic [3:0] a, input logic [31:0] dw,
                     output logic [1:0] rr);
    logic ta, tw, tb, done;
    // let an edge pass so a previous release is not overwritten
    @(posedge clk);
    axi_in.awaddr <= a;
    axi_in.wdata <= dw;
    axi_in.wstrb <= 4'hF;
    axi_in.awvalid <= 1'b1;
    axi_in.wvalid <= 1'b1;
    axi_in.bready <= 1'b1;
    done = 1'b0;
    rr = 2'h3;
    while (!done) begin
      @(negedge clk);
      ta = axi_in.awvalid & axo.awready;
      tw = axi_in.wvalid & axo.wready;
      tb = axo.bvalid;
      if (tb) rr = axo.bresp;
      @(posedge clk);
      if (ta) axi_in.awvalid <= 1'b0;
      if (tw) axi_in.wvalid <= 1'b0;
      if (tb) axi_in.bready <= 1'b0;
      done = tb;
    end
  endtask
  // AXI read: rready held until rvalid
  task automatic axr(input logic [3:0] a, output logic [31:0] dr,
                     output logic [1:0] rr);
    logic ta, done;
    @(posedge clk);
    axi_in.araddr <= a;
    axi_in.arvalid <= 1'b1;
    axi_in.rready <= 1'b1;
    done = 1'b0;
    rr = 2'h3;
    while (!done) begin
      @(negedge clk);
      ta = axi_in.arvalid & axo.arready;
      done = axo.rvalid;
      dr = axo.rdata;
      rr = axo.rresp;
      @(posedge clk);
      if (ta) axi_in.arvalid <= 1'b0;
      if (done) axi_in.rready <= 1'b0;
    end
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    axi_in = '0;
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    u_prog.enter();
    axr(CTRL_OFS, v, r);
    `CHK(v[CTRL_EN_BIT], CTRL_EN_RESET)
    `CHK(write_progress_out, 1'b1)
    axr(4'hC, v, r);
    `CHK({r, v}, {RESP_SLVERR, 32'h0})
    axw(STATUS_OFS, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    // identification bytes with all mode lines low
    for (i = 0; i < 3; i++) begin
      u_prog.read(MODE_READ_SIG, {1'b0, sig_a[i]}, d, oe);
      `CHK(d, sig_v[i])
    end
    // code write with the top address bit set, polled mid-write
    u_prog.step(MODE_WRITE_CODE, 15'h4123, 8'h5A, 1'b1);
    u_prog.pulse(20, busy, poll);
    `CHK(busy, 1'b1)
    `CHK(poll[POLL_BIT], 1'b1)
    u_prog.read(MODE_READ_CODE, 15'h4123, d, oe);
    `CHK(d, 8'h5A)
    axr(LAST_OFS, v, r);
    `CHK({r, v}, {RESP_OKAY, 32'h0000_4123})
    u_prog.read(MODE_READ_CODE, 15'h0123, d, oe);
    `CHK(d, ERASED)
    u_prog.read(MODE_READ_CODE, 15'h4124, d, oe);
    `CHK(d, ERASED)
    // strobe without program voltage, then with the port disabled
    u_prog.step(MODE_WRITE_CODE, 15'h0010, 8'h00, 1'b0);
    u_prog.pulse(20, busy, poll);
    `CHK(busy, 1'b0)
    axw(CTRL_OFS, 32'h0, r);
    `CHK(r, RESP_OKAY)
    u_prog.step(MODE_WRITE_CODE, 15'h0010, 8'h00, 1'b1);
    u_prog.pulse(20, busy, poll);
    `CHK(busy, 1'b0)
    axw(CTRL_OFS, 32'h1, r);
    u_prog.read(MODE_READ_CODE, 15'h0010, d, oe);
    `CHK(d, ERASED)
    // lock bits three, one, two with long strobes
    for (i = 0; i < 3; i++) begin
      u_prog.step(lk_m[i], 15'h0, 8'h00, 1'b1);
      u_prog.pulse(10000, busy, poll);
      `CHK(busy, 1'b1)
      u_prog.read(MODE_READ_LOCK, 15'h0, d, oe);
      `CHK(d[LOCK_DATA_LSB +: 3], lk_e[i])
    end
    axr(STATUS_OFS, v, r);
    `CHK(v[STAT_LOCK_LSB +: 3], 3'b111)
    u_prog.step(MODE_WRITE_CODE, 15'h0020, 8'h00, 1'b1);
    u_prog.pulse(20, busy, poll);
    `CHK(busy, 1'b0)
    u_prog.read(MODE_READ_CODE, 15'h4123, d, oe);
    `CHK(oe, 1'b0)
    // chip erase: two strobes, each waited out
    for (i = 0; i < 2; i++) begin
      u_prog.step(MODE_ERASE, 15'h0, 8'h00, 1'b1);
      u_prog.pulse(30, busy, poll);
      `CHK(busy, 1'b1)
    end
    u_prog.read(MODE_READ_LOCK, 15'h0, d, oe);
    `CHK(d[LOCK_DATA_LSB +: 3], 3'b000)
    u_prog.read(MODE_READ_CODE, 15'h4123, d, oe);
    `CHK({oe, d}, {1'b1, ERASED})
    close_out();
  end
endmodule
`default_nettype wire
